/* verilog/ascsm_map.svh */
/*
 Constants of the audio serial interface channel slot map: register indices,
 field positions, reset values and bus responses.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef ASCSM_MAP_SVH
`define ASCSM_MAP_SVH

// Register indices; byte address is four times the index
`define ASCSM_IDX_CH2 6'h0c
`define ASCSM_IDX_CH3 6'h0d
`define ASCSM_IDX_CH4 6'h0e
`define ASCSM_IDX_CH5 6'h0f

// Field positions inside a channel register
`define ASCSM_RSVD_BIT 7
`define ASCSM_LINE_BIT 6
`define ASCSM_SLOT_MSB 5
`define ASCSM_HALF_BIT 5

// Reset values of the channel registers
`define ASCSM_RST_CH2 8'h01
`define ASCSM_RST_CH3 8'h02
`define ASCSM_RST_CH4 8'h03
`define ASCSM_RST_CH5 8'h04

// Bus responses
`define ASCSM_RESP_OKAY 2'h0
`define ASCSM_RESP_SLVERR 2'h2

`endif

/* verilog/ascsm_pkg.sv */
/*
 Types of the audio serial interface channel slot map.
 Assumes the constants header is compiled alongside.
*/
package ascsm_pkg;

    // One channel slot register as stored
    typedef struct packed {
        logic rsvd;
        logic line_sel;
        logic [5:0] slot;
    } ascsm_chcfg_t;

    // Decoded placement of one channel in the frame
    typedef struct packed {
        logic right_half;
        logic [5:0] slot;
    } ascsm_place_t;

endpackage

/* verilog/ascsm_slot_map.sv */
/*
 Channel slot map for channels 2 to 5 of the audio serial interface, with an
 AXI4-Lite register slave and decoded per-channel slot placement.
 Assumes the framing engine shares aclk and drives the format select.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ascsm_map.svh"

module ascsm_slot_map
    import ascsm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Framing engine side
    input wire logic fmt_tdm,
    output logic [3:0] line_sel_q,
    output ascsm_place_t [3:0] place_q
);

    ascsm_chcfg_t cfg_q [4];
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic do_write;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic w_hit;
    logic r_hit;
    logic [1:0] wch;
    logic [1:0] rch;

    // Reset value of a channel register by position
    function automatic ascsm_chcfg_t rst_val(input int ch);
        ascsm_chcfg_t v;
        v = `ASCSM_RST_CH2;
        case (ch)
            1: v = `ASCSM_RST_CH3;
            2: v = `ASCSM_RST_CH4;
            3: v = `ASCSM_RST_CH5;
            default: v = `ASCSM_RST_CH2;
        endcase
        return v;
    endfunction

    // Address decode: four consecutive word indices
    assign widx = awaddr_q[7:2];
    assign ridx = araddr[7:2];
    // Upper address bits must be zero; a shift stays legal when ADDR_W is 8
    assign w_hit = (widx >= `ASCSM_IDX_CH2) && (widx <= `ASCSM_IDX_CH5)
        && ((awaddr_q >> 8) == '0);
    assign r_hit = (ridx >= `ASCSM_IDX_CH2) && (ridx <= `ASCSM_IDX_CH5)
        && ((araddr >> 8) == '0);
    assign wch = 2'(widx - `ASCSM_IDX_CH2);
    assign rch = 2'(ridx - `ASCSM_IDX_CH2);
    assign do_write = !awready && !wready && !bvalid;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awaddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response once both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `ASCSM_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= w_hit ? `ASCSM_RESP_OKAY : `ASCSM_RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Channel registers; reserved bit always stored as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                cfg_q[i] <= rst_val(i);
            end
        end else if (do_write && w_hit && wstrb0_q) begin
            cfg_q[wch].rsvd <= 1'b0;
            cfg_q[wch].line_sel <= wdata_q[`ASCSM_LINE_BIT];
            cfg_q[wch].slot <= wdata_q[`ASCSM_SLOT_MSB:0];
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `ASCSM_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= r_hit ? {24'h0, 1'b0, cfg_q[rch][6:0]} : 32'h0;
            rresp <= r_hit ? `ASCSM_RESP_OKAY : `ASCSM_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Placement decode per channel for the framing engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                line_sel_q[i] <= 1'b0;
                place_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                line_sel_q[i] <= cfg_q[i].line_sel;
                if (fmt_tdm) begin
                    place_q[i].right_half <= 1'b0;
                    place_q[i].slot <= cfg_q[i].slot;
                end else begin
                    place_q[i].right_half <= cfg_q[i].slot[`ASCSM_HALF_BIT];
                    place_q[i].slot <= {1'b0, cfg_q[i].slot[4:0]};
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_slot_vals: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> cfg_q[0].slot == 6'h01 && cfg_q[1].slot == 6'h02
            && cfg_q[2].slot == 6'h03 && !cfg_q[0].line_sel)
        else $error("channel 2-4 slot reset value wrong");

    a_ch5_reset_val: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> cfg_q[3] == 8'h04)
        else $error("channel 5 reset value wrong");

    // Decode checks start only from an edge that the logic saw out of reset
    a_line_sel_route: assert property (
        aresetn |=> line_sel_q[0] == $past(cfg_q[0].line_sel))
        else $error("line select does not follow register");

    a_tdm_slot_exact: assert property (
        aresetn && fmt_tdm |=> place_q[1].slot == $past(cfg_q[1].slot)
            && !place_q[1].right_half)
        else $error("TDM slot differs from field");

    a_left_half_map: assert property (
        aresetn && !fmt_tdm && !cfg_q[0].slot[5] |=> !place_q[0].right_half
            && place_q[0].slot == $past(cfg_q[0].slot))
        else $error("left half placement wrong");

    a_right_half_map: assert property (
        aresetn && !fmt_tdm && cfg_q[2].slot[5] |=> place_q[2].right_half
            && place_q[2].slot == 6'($past(cfg_q[2].slot) - 6'h20))
        else $error("right half placement wrong");

    a_read_decode: assert property (
        arvalid && arready && araddr == 8'h34 |=> rvalid && rdata == {24'h0, cfg_q[1]})
        else $error("channel 3 read decode wrong");

    a_write_decode: assert property (
        do_write && awaddr_q == 8'h38 && wstrb0_q
            |=> cfg_q[2][6:0] == $past(wdata_q[6:0]) && !cfg_q[2].rsvd)
        else $error("channel 4 write decode wrong");

    a_rsvd_reads_zero: assert property (
        rvalid |-> rdata[31:7] == 25'h0 && !cfg_q[0].rsvd && !cfg_q[3].rsvd)
        else $error("reserved bit not zero");

    a_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    c_write_done: cover property (do_write && w_hit ##1 bvalid && bready);
    c_read_done: cover property (arvalid && arready ##1 rvalid && rready);
    c_right_half: cover property (!fmt_tdm && cfg_q[0].slot[5]);
    c_unmapped: cover property (rvalid && rresp == `ASCSM_RESP_SLVERR);

endmodule

/* bench/ascsm_frame_model.sv */
/*
 Framing engine stand-in: presents the format select to the slot map.
 Assumes the same aclk; the bench asks for a format through want_tdm.
*/
`timescale 1ns/1ps
module ascsm_frame_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench request and format output
    input wire logic want_tdm,
    output logic fmt_tdm
);
    // Format changes only on a clock edge, TDM while reset is low
    always_ff @(posedge aclk) begin
        fmt_tdm <= !aresetn || want_tdm;
    end
endmodule

/* bench/ascsm_slot_map_tb_top.sv */
/*
 Register and placement tests of the channel slot map over AXI4-Lite.
 Assumes the design's 1-cycle read and 2-cycle write answers; waits are bounded anyway.
*/
`timescale 1ns/1ps
module ascsm_slot_map_tb_top;
    import ascsm_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, want_tdm = 1, fmt_tdm;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf, line_sel_q;
    logic [1:0] bresp, rresp, r;
    ascsm_place_t [3:0] place_q;
    int n_errors = 0, check_count = 0;

    // Design and far-side model
    ascsm_slot_map #(.ADDR_W(8)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .fmt_tdm, .line_sel_q, .place_q);
    ascsm_frame_model frame_u (.aclk, .aresetn, .want_tdm, .fmt_tdm);

    // 50 ns clock
    initial begin
        forever #25 aclk = !aclk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One write; each channel released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        logic ta, tw, tb;
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int n = 0; n < 40; n++) begin
            #1 ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; s = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) begin
                bready <= 0;
                @(posedge aclk);
                return;
            end
        end
        n_errors++;
        print_verdict();
    endtask

    // One read; data and response taken at the rvalid edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        logic ta, tb;
        araddr <= a; arvalid <= 1; rready <= 1;
        for (int n = 0; n < 40; n++) begin
            #1 ta = arvalid && arready; tb = rvalid; v = rdata; s = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (tb) begin
                rready <= 0;
                @(posedge aclk);
                return;
            end
        end
        n_errors++;
        print_verdict();
    endtask

    // Lets the placement follow a register or format change
    task automatic settle();
        repeat (4) @(posedge aclk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        // Reset values, addresses and default placement of channels 2 to 5
        for (int i = 0; i < 4; i++) begin
            rd(8'h30 + 8'(4 * i), d, r);
            chk(d, 32'(i + 1));
            chk(32'(r), 32'h0);
            chk(32'(place_q[i]), 32'(i + 1));
        end
        chk(32'(line_sel_q), 32'h0);
        $display("test reset done");
        // All ones: reserved bit dropped, secondary line, top slot
        wr(8'h30, 32'h0000_00ff, r);
        chk(32'(r), 32'h0);
        rd(8'h30, d, r);
        chk(d, 32'h7f);
        settle();
        chk(32'(line_sel_q), 32'h1);
        chk(32'(place_q[0]), {25'h0, 1'b0, 6'h3f});
        want_tdm <= 0;
        settle();
        chk(32'(place_q[0]), {25'h0, 1'b1, 6'h1f});
        $display("test line and tdm done");
        // Half-frame boundaries 31 and 32
        wr(8'h34, 32'h1f, r);
        wr(8'h38, 32'h20, r);
        settle();
        chk(32'(place_q[1]), {25'h0, 1'b0, 6'h1f});
        chk(32'(place_q[2]), {25'h0, 1'b1, 6'h00});
        $display("test half frame done");
        // Unmapped place and a write with lane 0 disabled
        wr(8'h40, 32'h55, r);
        chk(32'(r), 32'h2);
        rd(8'h40, d, r);
        chk({d[29:0], r}, 32'h2);
        wstrb <= 4'he;
        wr(8'h3c, 32'h3f, r);
        chk(32'(r), 32'h0);
        rd(8'h3c, d, r);
        chk(d, 32'h4);
        $display("test refusals done");
        // Second reset in mid-run brings every register back
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h30, d, r);
        chk(d, 32'h1);
        settle();
        for (int i = 0; i < 4; i++) begin
            chk(32'(place_q[i]), 32'(i + 1));
        end
        chk(32'(line_sel_q), 32'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule
